// >>> include/tfgs_map.svh
// timing counts and field constants of the thermal gate and group switch
`ifndef TFGS_MAP_SVH
`define TFGS_MAP_SVH
`define TFGS_CHANNELS 16
`define TFGS_GROUPS 4
`define TFGS_STAGGER_NS 200
`define TFGS_CLK_NS 100
`define TFGS_STAGGER_CYC ((`TFGS_STAGGER_NS + `TFGS_CLK_NS - 1) / `TFGS_CLK_NS)
`define TFGS_GROUP0_MASK 16'h8181
`define TFGS_GROUP1_MASK 16'h4242
`define TFGS_GROUP2_MASK 16'h2424
`define TFGS_GROUP3_MASK 16'h1818
`endif

// >>> include/tfgs_pkg.sv
// types of the thermal gate and group switch
package tfgs_pkg;
   typedef enum logic [1:0] {
      TFGS_RUN,
      TFGS_FAULT,
      TFGS_WAIT_PERIOD
   } tfgs_state_e;
endpackage

// >>> src/tfgs_stagger.sv
// four-group staggered switching of the sink outputs
`timescale 1ns/100ps
`include "tfgs_map.svh"
module tfgs_stagger #(
   parameter int STAGGER = `TFGS_STAGGER_CYC
) (
   input wire logic mclk,                 // system clock
   input wire logic reset,                // sync reset, active high
   input wire logic forceOff,             // drop all groups at once
   input wire logic [15:0] chanOn,        // requested channel levels
   output logic [15:0] sinkOutput         // staggered sink enables
);
   typedef struct packed {
      logic [3:0][15:0] stage;
      logic [7:0] tick;
      logic [15:0] outs;
   } tfgs_stg_s;
   tfgs_stg_s st_reg, st_next;
   localparam logic [15:0] GMASK [4] = '{`TFGS_GROUP0_MASK, `TFGS_GROUP1_MASK,
                                        `TFGS_GROUP2_MASK, `TFGS_GROUP3_MASK};
   always_comb begin
      st_next = st_reg;
      st_next.tick = (st_reg.tick >= 8'(STAGGER - 1)) ? 8'h00 : st_reg.tick + 8'h01;
      if (st_reg.tick == 8'h00) begin
         // each group sees the request one stagger step after the previous one
         st_next.stage[0] = chanOn;
         for (int g = 1; g < `TFGS_GROUPS; g++) begin
            st_next.stage[g] = st_reg.stage[g-1];
         end
      end
      st_next.outs = 16'h0000;
      for (int g = 0; g < `TFGS_GROUPS; g++) begin
         st_next.outs = st_next.outs | (st_next.stage[g] & GMASK[g]);
      end
      if (forceOff) begin
         st_next.stage = '0;
         st_next.outs = 16'h0000;
      end
      if (reset) begin
         st_next = '0;
      end
   end
   always_ff @(posedge mclk) begin
      st_reg <= st_next;
   end
   assign sinkOutput = st_reg.outs;
endmodule

// >>> src/tfgs_thermal_gate.sv
// thermal fault latch and output gate of a 16-channel sink driver
// Function
// - overtemp forces outputs off, sets flag
// - outputs stay off until new cycle and cool
// - flag holds until strobe edge and cool
// - after clear, wait first grayscale clock of period
// - four groups: 0/7/8/15, 1/6/9/14, 2/5/10/13, 3/4/11/12
// - groups switch in order with fixed delay
// - each output timed by grayscale clock
// - grayscale-write strobe edge clears flag if cool
// - re-enable at grayscale edge, cool, blank low
`timescale 1ns/100ps
`include "tfgs_map.svh"
module tfgs_thermal_gate #(
   parameter int STAGGER = `TFGS_STAGGER_CYC
) (
   input wire logic mclk,                 // system clock, 10 MHz
   input wire logic reset,                // sync reset, active high
   input wire logic latch_strobe,         // latch strobe level from controller
   input wire logic grayscaleWrite,       // current latch is a grayscale write
   input wire logic grayscale_clock,      // grayscale clock level
   input wire logic periodStart,          // pulse: new display period begins
   input wire logic blank,                // blanking input, high forces off
   input wire logic overTemp,             // comparator: above shutdown threshold
   input wire logic coolEnough,           // comparator: below threshold minus hysteresis
   input wire logic [15:0] pwmLevel,      // per-channel grayscale pwm request
   output logic thermal_error_flag,       // thermal error flag
   output logic thermal_shutdown,         // outputs held off by thermal fault
   output logic [15:0] sink_output_n      // staggered sink enables
);
   typedef struct packed {
      tfgs_pkg::tfgs_state_e state;
      logic flag;
      logic shut;
      logic latPrev;
      logic gsPrev;
      logic hot;
      logic cool;
      logic cycleSeen;
      logic [15:0] chan;
      logic [15:0] outs;
      logic [7:0] age;
   } tfgs_gate_s;
   tfgs_gate_s st_reg, st_next;
   logic latRise, gsRise, gateOff;
   logic [15:0] staggered;
   // cycles after which every group has followed a steady request
   localparam logic [7:0] SETTLE = 8'(`TFGS_GROUPS * STAGGER + 1);

   assign latRise = latch_strobe & ~st_reg.latPrev;
   assign gsRise = grayscale_clock & ~st_reg.gsPrev;

   always_comb begin
      st_next = st_reg;
      st_next.latPrev = latch_strobe;
      st_next.gsPrev = grayscale_clock;
      if (gsRise) begin
         st_next.hot = overTemp;
         st_next.cool = coolEnough;
         st_next.chan = pwmLevel;
      end
      case (st_reg.state)
         tfgs_pkg::TFGS_RUN: begin
            if (st_reg.hot) begin
               st_next.flag = 1'b1;
               st_next.cycleSeen = 1'b0;
               st_next.state = tfgs_pkg::TFGS_FAULT;
            end
         end
         tfgs_pkg::TFGS_FAULT: begin
            // clear only on a grayscale-write strobe edge while cool; heating wins
            if (latRise && grayscaleWrite && st_reg.cool && !st_reg.hot) begin
               st_next.flag = 1'b0;
               // a period that began during the fault does not count
               st_next.cycleSeen = 1'b0;
               st_next.state = tfgs_pkg::TFGS_WAIT_PERIOD;
            end
         end
         tfgs_pkg::TFGS_WAIT_PERIOD: begin
            if (st_reg.hot) begin
               st_next.flag = 1'b1;
               st_next.state = tfgs_pkg::TFGS_FAULT;
            end else if (periodStart) begin
               st_next.cycleSeen = 1'b1;
            end else if (gsRise && st_reg.cycleSeen && st_reg.cool && !blank) begin
               st_next.state = tfgs_pkg::TFGS_RUN;
            end
         end
         default: begin
            st_next.state = tfgs_pkg::TFGS_RUN;
         end
      endcase
      st_next.shut = st_next.state != tfgs_pkg::TFGS_RUN;
      st_next.outs = (st_reg.state == tfgs_pkg::TFGS_RUN && !blank) ? staggered : 16'h0000;
      // settle count for the output check: restarts on a new request, a gate change or blank
      if (st_next.chan != st_reg.chan || st_next.shut || blank) begin
         st_next.age = 8'h00;
      end else if (st_reg.age != 8'hFF) begin
         st_next.age = st_reg.age + 8'h01;
      end
      if (reset) begin
         st_next = '0;
      end
   end

   always_ff @(posedge mclk) begin
      st_reg <= st_next;
   end

   assign gateOff = (st_next.state != tfgs_pkg::TFGS_RUN) || blank;

   tfgs_stagger #(.STAGGER(STAGGER)) u_stagger (
      .mclk(mclk),
      .reset(reset),
      .forceOff(gateOff),
      .chanOn(st_reg.chan),
      .sinkOutput(staggered)
   );

   assign thermal_error_flag = st_reg.flag;
   assign thermal_shutdown = st_reg.shut;
   assign sink_output_n = st_reg.outs;

   property p_fault_off;
      @(posedge mclk) disable iff (reset)
      (st_reg.state == tfgs_pkg::TFGS_FAULT) |=> sink_output_n == 16'h0000;
   endproperty
   a_fault_off: assert property (p_fault_off) else $error("outputs on during fault");

   property p_hot_sets_flag;
      @(posedge mclk) disable iff (reset)
      (st_reg.state == tfgs_pkg::TFGS_RUN && st_reg.hot) |=> thermal_error_flag;
   endproperty
   a_hot_sets_flag: assert property (p_hot_sets_flag) else $error("flag not set when hot");

   property p_flag_holds;
      @(posedge mclk) disable iff (reset)
      (thermal_error_flag && !(latRise && grayscaleWrite && st_reg.cool)) |=> thermal_error_flag;
   endproperty
   a_flag_holds: assert property (p_flag_holds) else $error("flag cleared without cause");

   property p_clear_cause;
      @(posedge mclk) disable iff (reset)
      $fell(thermal_error_flag) && !$past(reset)
         |-> $past(latRise) && $past(grayscaleWrite) && $past(st_reg.cool);
   endproperty
   a_clear_cause: assert property (p_clear_cause) else $error("flag fell without strobe");

   sequence s_waiting;
      st_reg.state == tfgs_pkg::TFGS_WAIT_PERIOD;
   endsequence
   property p_wait_off;
      @(posedge mclk) disable iff (reset)
      s_waiting |=> sink_output_n == 16'h0000;
   endproperty
   a_wait_off: assert property (p_wait_off) else $error("outputs on before new period");

   property p_rearm;
      @(posedge mclk) disable iff (reset)
      (st_reg.state == tfgs_pkg::TFGS_WAIT_PERIOD) ##1 (st_reg.state == tfgs_pkg::TFGS_RUN)
         |-> $past(gsRise) && !$past(blank) && $past(st_reg.cycleSeen);
   endproperty
   a_rearm: assert property (p_rearm) else $error("rearm without grayscale edge");

   property p_blank_off;
      @(posedge mclk) disable iff (reset)
      blank |=> sink_output_n == 16'h0000;
   endproperty
   a_blank_off: assert property (p_blank_off) else $error("outputs on while blanked");

   property p_group_mask;
      @(posedge mclk) disable iff (reset)
      (st_reg.age >= SETTLE) |-> sink_output_n == st_reg.chan;
   endproperty
   a_group_mask: assert property (p_group_mask) else $error("outputs differ from settled request");

   property p_flag_shutdown;
      @(posedge mclk) disable iff (reset)
      thermal_error_flag |-> thermal_shutdown;
   endproperty
   a_flag_shutdown: assert property (p_flag_shutdown) else $error("flag set while outputs released");

   sequence s_no_new_period;
      st_reg.state == tfgs_pkg::TFGS_WAIT_PERIOD && !st_reg.cycleSeen && !periodStart;
   endsequence
   property p_wait_period;
      @(posedge mclk) disable iff (reset)
      s_no_new_period |=> st_reg.state != tfgs_pkg::TFGS_RUN;
   endproperty
   a_wait_period: assert property (p_wait_period) else $error("rearm before new display period");

   property p_refault;
      @(posedge mclk) disable iff (reset)
      (st_reg.state == tfgs_pkg::TFGS_WAIT_PERIOD && st_reg.hot)
         |=> st_reg.state == tfgs_pkg::TFGS_FAULT && thermal_error_flag;
   endproperty
   a_refault: assert property (p_refault) else $error("heat while waiting did not relatch");

   property p_hot_blocks_clear;
      @(posedge mclk) disable iff (reset)
      (thermal_error_flag && st_reg.hot) |=> thermal_error_flag;
   endproperty
   a_hot_blocks_clear: assert property (p_hot_blocks_clear) else $error("flag cleared while hot");

   property p_sample;
      @(posedge mclk) disable iff (reset)
      gsRise |=> st_reg.chan == $past(pwmLevel) && st_reg.hot == $past(overTemp)
         && st_reg.cool == $past(coolEnough);
   endproperty
   a_sample: assert property (p_sample) else $error("levels not taken at grayscale edge");
endmodule

// >>> verif/tfgs_ctrl_model.sv
// display controller model: grayscale clock and latch strobe
`timescale 1ns/100ps
module tfgs_ctrl_model (
   input wire logic mclk,        // system clock
   output logic grayscale_clock, // grayscale clock level
   output logic latch_strobe,    // latch strobe level
   output logic grayscaleWrite   // strobe is a grayscale write
);
   initial begin
      grayscale_clock = 1'b0;
      latch_strobe = 1'b0;
      grayscaleWrite = 1'b0;
   end
   task automatic gs_rise();
      @(posedge mclk) #10 grayscale_clock = 1'b1;
      // return past the edge so callers never sample or drive on it
      @(posedge mclk);
      #10;
   endtask
   task automatic gs_fall();
      @(posedge mclk) #10 grayscale_clock = 1'b0;
      @(posedge mclk);
      #10;
   endtask
   // qualifier is held across the whole strobe
   task automatic strobe(input logic gsWrite);
      @(posedge mclk) #10 grayscaleWrite = gsWrite;
      @(posedge mclk) #10 latch_strobe = 1'b1;
      repeat (2) @(posedge mclk);
      #10 latch_strobe = 1'b0;
      @(posedge mclk) #10 grayscaleWrite = 1'b0;
   endtask
endmodule

// >>> verif/tb.sv
// self-checking bench of the thermal gate and group switch
`timescale 1ns/100ps
`include "tfgs_map.svh"
module tb;
   logic mclk = 1'b0, reset = 1'b1, periodStart = 1'b0, blank = 1'b0, overTemp = 1'b0, coolEnough = 1'b1;
   logic [15:0] pwmLevel = 16'h0000;
   wire logic latchStrobe, gsWrite, gsClock, flag, shutdown;
   wire logic [15:0] sinkOut;
   int errors = 0;
   int compares = 0;
   localparam logic [15:0] G0 = `TFGS_GROUP0_MASK, G1 = `TFGS_GROUP1_MASK;
   localparam logic [15:0] G2 = `TFGS_GROUP2_MASK, G3 = `TFGS_GROUP3_MASK;
   tfgs_ctrl_model tfgs_ctrl_model_i (.mclk(mclk), .grayscale_clock(gsClock), .latch_strobe(latchStrobe),
      .grayscaleWrite(gsWrite));
   tfgs_thermal_gate #(.STAGGER(2)) tfgs_thermal_gate_i (.mclk(mclk), .reset(reset), .latch_strobe(latchStrobe),
      .grayscaleWrite(gsWrite), .grayscale_clock(gsClock), .periodStart(periodStart), .blank(blank),
      .overTemp(overTemp), .coolEnough(coolEnough), .pwmLevel(pwmLevel), .thermal_error_flag(flag),
      .thermal_shutdown(shutdown), .sink_output_n(sinkOut));
   always #50 mclk = ~mclk;
   task automatic give_verdict();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #10;
   endtask
   // waits for an exact output pattern, then walks the groups
   task automatic walk(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
      int n;
      n = 0;
      while (sinkOut !== a && n < 40) begin
         cyc(1);
         n++;
      end
      chk("first group", sinkOut, a);
      if (n == 40) give_verdict();
      cyc(2);
      chk("second group", sinkOut, b);
      cyc(2);
      chk("third group", sinkOut, c);
   endtask
   task automatic sc_stagger();
      pwmLevel = 16'hFFFF;
      tfgs_ctrl_model_i.gs_rise();
      walk(G0, G0 | G1, G0 | G1 | G2);
      cyc(2);
      chk("all on", sinkOut, 16'hFFFF);
      tfgs_ctrl_model_i.gs_fall();
      pwmLevel = 16'h0000;
      tfgs_ctrl_model_i.gs_rise();
      walk(G1 | G2 | G3, G2 | G3, G3);
      tfgs_ctrl_model_i.gs_fall();
      pwmLevel = 16'hFFFF;
   endtask
   task automatic sc_fault();
      overTemp = 1'b1;
      coolEnough = 1'b0;
      tfgs_ctrl_model_i.gs_rise();
      tfgs_ctrl_model_i.gs_fall();
      cyc(1);
      chk("flag set", {15'h0000, flag}, 16'h0001);
      chk("outputs forced off", sinkOut, 16'h0000);
      overTemp = 1'b0;
      tfgs_ctrl_model_i.strobe(1'b1);
      chk("flag while warm", {15'h0000, flag}, 16'h0001);
      coolEnough = 1'b1;
      tfgs_ctrl_model_i.gs_rise();
      tfgs_ctrl_model_i.gs_fall();
      chk("flag cool no strobe", {15'h0000, flag}, 16'h0001);
      chk("off cool no strobe", sinkOut, 16'h0000);
      tfgs_ctrl_model_i.strobe(1'b0);
      chk("flag non-gs strobe", {15'h0000, flag}, 16'h0001);
      tfgs_ctrl_model_i.strobe(1'b1);
      chk("flag cleared", {15'h0000, flag}, 16'h0000);
      chk("shutdown held", {15'h0000, shutdown}, 16'h0001);
      tfgs_ctrl_model_i.gs_rise();
      tfgs_ctrl_model_i.gs_fall();
      cyc(4);
      chk("off before period", sinkOut, 16'h0000);
      periodStart = 1'b1;
      cyc(1);
      periodStart = 1'b0;
      blank = 1'b1;
      tfgs_ctrl_model_i.gs_rise();
      tfgs_ctrl_model_i.gs_fall();
      cyc(4);
      chk("off while blank", sinkOut, 16'h0000);
      blank = 1'b0;
      tfgs_ctrl_model_i.gs_rise();
      walk(G0, G0 | G1, G0 | G1 | G2);
      chk("shutdown released", {15'h0000, shutdown}, 16'h0000);
      tfgs_ctrl_model_i.gs_fall();
   endtask
   // period seen before the clear is ignored, heat while waiting relatches, then a reset while the fault is latched
   task automatic sc_refault();
      overTemp = 1'b1;
      coolEnough = 1'b0;
      tfgs_ctrl_model_i.gs_rise();
      tfgs_ctrl_model_i.gs_fall();
      chk("refault flag", {15'h0000, flag}, 16'h0001);
      chk("refault shutdown", {15'h0000, shutdown}, 16'h0001);
      chk("refault outputs", sinkOut, 16'h0000);
      overTemp = 1'b0;
      coolEnough = 1'b1;
      periodStart = 1'b1;
      cyc(1);
      periodStart = 1'b0;
      tfgs_ctrl_model_i.gs_rise();
      tfgs_ctrl_model_i.gs_fall();
      tfgs_ctrl_model_i.strobe(1'b1);
      chk("reclear flag", {15'h0000, flag}, 16'h0000);
      tfgs_ctrl_model_i.gs_rise();
      tfgs_ctrl_model_i.gs_fall();
      cyc(2);
      chk("off after early period", sinkOut, 16'h0000);
      chk("shutdown after early period", {15'h0000, shutdown}, 16'h0001);
      overTemp = 1'b1;
      coolEnough = 1'b0;
      tfgs_ctrl_model_i.gs_rise();
      tfgs_ctrl_model_i.gs_fall();
      chk("flag hot while waiting", {15'h0000, flag}, 16'h0001);
      chk("off hot while waiting", sinkOut, 16'h0000);
      overTemp = 1'b0;
      coolEnough = 1'b1;
      reset = 1'b1;
      cyc(1);
      reset = 1'b0;
      chk("flag after reset", {15'h0000, flag}, 16'h0000);
      chk("shutdown after reset", {15'h0000, shutdown}, 16'h0000);
      cyc(2);
      chk("outputs after reset", sinkOut, 16'h0000);
   endtask
   initial begin
      cyc(6);
      reset = 1'b0;
      chk("reset outputs", sinkOut, 16'h0000);
      sc_stagger();
      sc_fault();
      sc_refault();
      give_verdict();
   end
endmodule
